// file: logic/itpm_defs.svh
// constants for the codepoint priority map: register indices, field layout, reset values
// assumes inclusion by the map module, the package and the bench
`ifndef ITPM_DEFS_SVH
`define ITPM_DEFS_SVH

// register indices as printed; byte address is four times the index
`define ITPM_IDX_CODES_00_03 8'h90
`define ITPM_IDX_CODES_04_07 8'h91
`define ITPM_IDX_CODES_08_0B 8'h92
`define ITPM_IDX_CODES_0C_0F 8'h93
`define ITPM_IDX_ADDR_PAD 22'h000000
`define ITPM_MAP_RST 8'h00
`define ITPM_NUM_REGS 4
`define ITPM_FIELD_W 2
`define ITPM_CODE_LO 2
`define ITPM_CODE_HI 7
`define ITPM_LOCAL_LIMIT 6'h10
`define ITPM_HTRANS_IDLE 2'h0
`define ITPM_HRESP_OKAY 1'h0

`endif

// file: logic/itpm_pkg.sv
// types shared by the codepoint priority map and its neighbours
// assumes the defs header is on the include path
`include "itpm_defs.svh"

package itpm_pkg;

   typedef logic [7:0] itpm_map_reg_t;
   typedef itpm_map_reg_t [`ITPM_NUM_REGS-1:0] itpm_table_t;

   // lookup request from ingress classification
   typedef struct packed {
      logic valid;
      logic [7:0] tos;
      logic [1:0] ext_prio;
   } itpm_req_t;

   // lookup answer, one cycle after the request
   typedef struct packed {
      logic valid;
      logic [1:0] prio;
   } itpm_ans_t;

endpackage

// file: logic/itpm_map.sv
// codepoint-to-priority map for codepoints 0x00-0x0F, with AHB-Lite register access
// assumes one 250 MHz clock, async active-low reset, a single AHB-Lite master,
// and that the neighbouring table slice for codepoints 0x10-0x3F drives ext_prio
// Operation
// - priority comes from a 16-entry table of 2-bit fields for codepoints 0x00-0x0F, from ext_prio above that
// - tos bits [7:2] form the codepoint that selects one 2-bit field
// - first map register: codepoints 0x00..0x03 use bits 1:0, 3:2, 5:4, 7:6
// - second map register: codepoints 0x04..0x07 use bits 1:0, 3:2, 5:4, 7:6
// - third map register: codepoints 0x08..0x0B use bits 1:0, 3:2, 5:4, 7:6
// - fourth map register: codepoints 0x0C..0x0F use bits 1:0, 3:2, 5:4, 7:6
//
// Local design decision: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "itpm_defs.svh"

module itpm_map
   import itpm_pkg::*;
(
   input wire logic clock,
   input wire logic reset_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire itpm_req_t lookup_req,
   output itpm_ans_t lookup_ans
);

   localparam logic [7:0] IDX [`ITPM_NUM_REGS] = '{`ITPM_IDX_CODES_00_03,
      `ITPM_IDX_CODES_04_07, `ITPM_IDX_CODES_08_0B, `ITPM_IDX_CODES_0C_0F};

   // bus state
   logic wr_pend, next_wr_pend;
   logic [`ITPM_NUM_REGS-1:0] wr_sel, next_wr_sel;
   logic [31:0] next_hrdata;
   itpm_table_t map_table, next_map_table;
   itpm_ans_t next_lookup_ans;
   logic addr_phase;
   logic [`ITPM_NUM_REGS-1:0] hit;

   assign addr_phase = hsel && htrans[1] && hready;

   // per-register address decode
   genvar g;
   generate
      for (g = 0; g < `ITPM_NUM_REGS; g++) begin : g_dec
         assign hit[g] = (haddr[31:2] == {`ITPM_IDX_ADDR_PAD, IDX[g]});
      end
   endgenerate

   always_comb begin
      next_map_table = map_table;
      for (int i = 0; i < `ITPM_NUM_REGS; i++) begin
         if (wr_pend && wr_sel[i]) begin
            next_map_table[i] = hwdata[7:0];
         end
      end
      next_wr_pend = wr_pend;
      next_wr_sel = wr_sel;
      next_hrdata = hrdata;
      if (hready) begin
         next_wr_pend = addr_phase && hwrite;
         next_wr_sel = hit;
         next_hrdata = 32'h0000_0000;
         // read sees a write finishing in the same cycle; unmapped reads zero
         if (addr_phase && !hwrite) begin
            for (int i = 0; i < `ITPM_NUM_REGS; i++) begin
               if (hit[i]) begin
                  next_hrdata = {24'h00_0000, next_map_table[i]};
               end
            end
         end
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         wr_pend <= 1'b0;
         wr_sel <= '0;
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= `ITPM_HRESP_OKAY;
         for (int i = 0; i < `ITPM_NUM_REGS; i++) begin
            map_table[i] <= `ITPM_MAP_RST;
         end
      end else begin
         wr_pend <= next_wr_pend;
         wr_sel <= next_wr_sel;
         hrdata <= next_hrdata;
         hreadyout <= 1'b1;
         hresp <= `ITPM_HRESP_OKAY;
         map_table <= next_map_table;
      end
   end

   // lookup: codepoint bits [3:2] pick the register, bits [1:0] the field within it
   logic [5:0] code;
   logic [1:0] local_prio;
   assign code = lookup_req.tos[`ITPM_CODE_HI:`ITPM_CODE_LO];

   always_comb begin
      // table read before this edge's write lands, so a same-edge write is not seen
      local_prio = map_table[code[3:2]][{code[1:0], 1'b0} +: `ITPM_FIELD_W];
      next_lookup_ans.valid = lookup_req.valid;
      next_lookup_ans.prio = lookup_ans.prio;
      if (lookup_req.valid) begin
         next_lookup_ans.prio = (code < `ITPM_LOCAL_LIMIT) ? local_prio
            : lookup_req.ext_prio;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         lookup_ans <= '0;
      end else begin
         lookup_ans <= next_lookup_ans;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);

   property p_ans_follows_req;
      lookup_req.valid |=> lookup_ans.valid ##1 (lookup_ans.valid == $past(lookup_req.valid));
   endproperty
   a_ans_follows_req: assert property (p_ans_follows_req) else $error("answer valid mismatch");

   property p_low_bits_ignored;
      lookup_req.valid && lookup_req.tos[7:2] == 6'h01
         |=> lookup_ans.prio == $past(map_table[0][3:2]);
   endproperty
   a_low_bits_ignored: assert property (p_low_bits_ignored) else $error("code 0x01 wrong");

   property p_reg0_top;
      lookup_req.valid && code == 6'h03 |=> lookup_ans.prio == $past(map_table[0][7:6]);
   endproperty
   a_reg0_top: assert property (p_reg0_top) else $error("code 0x03 wrong field");

   property p_reg1_low;
      lookup_req.valid && code == 6'h04 |=> lookup_ans.prio == $past(map_table[1][1:0]);
   endproperty
   a_reg1_low: assert property (p_reg1_low) else $error("code 0x04 wrong field");

   property p_reg2_mid;
      lookup_req.valid && code == 6'h0A |=> lookup_ans.prio == $past(map_table[2][5:4]);
   endproperty
   a_reg2_mid: assert property (p_reg2_mid) else $error("code 0x0A wrong field");

   property p_reg3_top;
      lookup_req.valid && code == 6'h0F |=> lookup_ans.prio == $past(map_table[3][7:6]);
   endproperty
   a_reg3_top: assert property (p_reg3_top) else $error("code 0x0F wrong field");

   property p_ext_range;
      lookup_req.valid && code >= 6'h10 |=> lookup_ans.prio == $past(lookup_req.ext_prio);
   endproperty
   a_ext_range: assert property (p_ext_range) else $error("extension prio not used");

   // unmapped writes leave the table alone
   property p_stray_write;
      wr_pend && wr_sel == '0 |=> $stable(map_table);
   endproperty
   a_stray_write: assert property (p_stray_write) else $error("stray write changed table");

   // read data is zero except in the data phase of a mapped read
   property p_rd_idle_zero;
      hready && !(addr_phase && !hwrite && |hit) |=> hrdata == 32'h0000_0000;
   endproperty
   a_rd_idle_zero: assert property (p_rd_idle_zero) else $error("read data not zero");

   // no request: no answer pulse, and the last priority stands
   property p_prio_holds;
      !lookup_req.valid |=> !lookup_ans.valid && $stable(lookup_ans.prio);
   endproperty
   a_prio_holds: assert property (p_prio_holds) else $error("idle answer changed");

   // held reset clears the table, the read data and the answer
   property p_reset_clear;
      @(posedge clock) disable iff (1'b0)
         !reset_n ##1 !reset_n |-> map_table == '0 && hrdata == 32'h0000_0000
            && lookup_ans == '0 && hreadyout;
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("reset left state");

   // per register: the data-phase byte lands, and a read returns the stored byte
   generate
      for (g = 0; g < `ITPM_NUM_REGS; g++) begin : g_reg_chk
         property p_wr_lands;
            wr_pend && wr_sel[g] |=> map_table[g] == $past(hwdata[7:0]);
         endproperty
         a_wr_lands: assert property (p_wr_lands) else $error("write lost");

         property p_rd_returns;
            addr_phase && !hwrite && hit[g] |=> hrdata == {24'h00_0000, map_table[g]};
         endproperty
         a_rd_returns: assert property (p_rd_returns) else $error("bad read");
      end
   endgenerate

   // every local codepoint reads its own field, one cycle after the request
   generate
      for (g = 0; g < `ITPM_LOCAL_LIMIT; g++) begin : g_code_chk
         property p_code_field;
            lookup_req.valid && code == 6'(g)
               |=> lookup_ans.prio == $past(map_table[g / 4][(g % 4) * 2 +: 2]);
         endproperty
         a_code_field: assert property (p_code_field) else $error("codepoint field wrong");
      end
   endgenerate

   property p_write_then_lookup;
      wr_pend && wr_sel[0] && !lookup_req.valid ##1 lookup_req.valid && code == 6'h02
         |=> lookup_ans.prio == $past(hwdata[5:4], 2);
   endproperty
   a_write_then_lookup: assert property (p_write_then_lookup) else $error("write lost");

endmodule
`default_nettype wire

// file: testbench/itpm_ingress_model.sv
// ingress classifier stand-in: sends one lookup and collects the answer
// assumes the map answers one cycle after the taking edge
`timescale 1ns/1ps
`default_nettype none
module itpm_ingress_model
   import itpm_pkg::*;
(
   input wire logic clock,
   output itpm_req_t lookup_req,
   input wire itpm_ans_t lookup_ans
);
   initial lookup_req = '0;
   task automatic ask(input logic [7:0] tos, input logic [1:0] ext, output logic [2:0] got);
      @(posedge clock);
      lookup_req <= '{valid: 1'b1, tos: tos, ext_prio: ext};
      @(posedge clock);
      // released fields show the inverse so stale values cannot pass
      lookup_req <= '{valid: 1'b0, tos: ~tos, ext_prio: ~ext};
      // the answer stands for the cycle after the taking edge
      @(posedge clock);
      got = lookup_ans;
   endtask
endmodule
`default_nettype wire

// file: testbench/itpm_map_tb.sv
// bench for the codepoint priority map: register access, lookups, reset
// assumes design files and the ingress model are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "itpm_defs.svh"
module itpm_map_tb
   import itpm_pkg::*;
;
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = '0;
   logic [1:0] htrans = `ITPM_HTRANS_IDLE;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = '0;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   itpm_req_t lookup_req;
   itpm_ans_t lookup_ans;
   int n_errors = 0;
   int cmp_count = 0;
   logic [7:0] pat [4] = '{8'h1B, 8'hE4, 8'h9C, 8'h63};
   logic [31:0] rd;
   logic [2:0] got;
   logic [5:0] c;
   logic [1:0] ep;
   always #2 clock = ~clock;
   itpm_map i_dut (.clock(clock), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .lookup_req(lookup_req),
      .lookup_ans(lookup_ans));
   itpm_ingress_model i_ing (.clock(clock), .lookup_req(lookup_req), .lookup_ans(lookup_ans));
   function automatic logic [31:0] reg_addr(input int i);
      return {`ITPM_IDX_ADDR_PAD, `ITPM_IDX_CODES_00_03 + i[7:0], 2'b00};
   endfunction
   task automatic test_done();
      $display("compares %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
      cmp_count++;
      if (seen !== exp) begin
         $display("BAD %s exp %h seen %h", what, exp, seen);
         n_errors++;
      end
   endtask
   task automatic wait_rdy();
      int n;
      n = 0;
      @(posedge clock);
      while (hreadyout !== 1'b1) begin
         n++;
         if (n > 50) begin
            n_errors++;
            test_done();
         end
         @(posedge clock);
      end
   endtask
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= a;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= `ITPM_HTRANS_IDLE;
      hwdata <= wd;
      wait_rdy();
      rd = hrdata;
      chk("resp", {31'h0, `ITPM_HRESP_OKAY}, {31'h0, hresp});
   endtask
   task automatic read_all(input logic on);
      for (int i = 0; i < 4; i++) begin
         bus(1'b0, reg_addr(i), 32'h0);
         chk("map reg", {24'h0, pat[i] & {8{on}}}, rd);
      end
   endtask
   initial begin
      repeat (20) @(posedge clock);
      reset_n <= 1'b1;
      @(posedge clock);
      read_all(1'b0);
      for (int i = 0; i < 4; i++) begin
         bus(1'b1, reg_addr(i), {24'hFFFFFF, pat[i]});
         bus(1'b0, reg_addr(i), 32'h0);
         chk("readback", {24'h0, pat[i]}, rd);
      end
      bus(1'b1, 32'h250, 32'hFF);
      bus(1'b0, 32'h250, 32'h0);
      chk("unmapped", 32'h0, rd);
      read_all(1'b1);
      for (int k = 0; k < 64; k++) begin
         c = k[5:0];
         ep = c < 6'h10 ? 2'(pat[c >> 2] >> (2 * c[1:0])) : ~c[1:0];
         i_ing.ask({c, 2'b11}, ~c[1:0], got);
         chk("prio", {29'h0, 1'b1, ep}, {29'h0, got});
      end
      // a lookup taken at the edge where a write lands still sees the old field
      fork
         bus(1'b1, reg_addr(0), 32'h2B);
         i_ing.ask(8'h08, 2'h0, got);
      join
      chk("old field", 32'h5, {29'h0, got});
      // one edge later the new field is used
      fork
         bus(1'b1, reg_addr(0), 32'h3B);
         begin
            @(posedge clock);
            i_ing.ask(8'h08, 2'h0, got);
         end
      join
      chk("new field", 32'h7, {29'h0, got});
      reset_n <= 1'b0;
      repeat (3) @(posedge clock);
      reset_n <= 1'b1;
      @(posedge clock);
      chk("answer after reset", 32'h0, {29'h0, lookup_ans});
      read_all(1'b0);
      test_done();
   end
endmodule
`default_nettype wire
